// ===== verilog/src_top.sv
// Purpose: Startup region, startup bank and code cache control with AXI4-Lite
// Assumes: Option memory levels arrive asynchronously on pins
// Notes:   Bus is refused until the startup values have been captured
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`include "src_defs.svh"
`default_nettype none
// Contract
// - Linear mode region select writes change the active region at once.
// - After reset the region select follows the option memory setting.
// - Region select offers follow, force zero, force one and swap.
// - Cache status reads 0 when disabled, 1 when enabled.
// - Reconfiguring a range with cache on disables it briefly.
// - Startup bank toggle takes effect only after the next reset.
// - Writing the bank selection raises the flash ready event.
// - Bank selection reads 1 for bank zero, 0 for bank one.
// - Dual bank and data flash speed exist only with 1.5 Mbyte flash or more.
// - A region swap also signals completion by the flash ready event.
module src_top #(
  parameter int CODE_FLASH_KB = 2048,
  parameter int ADDR_W        = 24
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              optSwapFlag,
  input  wire logic              optDualMode,
  input  wire logic              optBankCode,
  input  wire logic [ADDR_W-1:0] accessAddr,
  input  wire logic              accessValid,
  output var  logic              activeRegion,
  output var  logic              activeBank,
  output var  logic              cacheActive,
  output var  logic              accessCached,
  output var  logic              bankWrite,
  output var  logic              bankWriteData,
  output var  logic              flashReadyEvent,
  output var  logic [31:0]       flashFreq,
  output var  logic              dataFlashWait,
  output var  logic              irq
);
  localparam bit BIG = (CODE_FLASH_KB >= 1536);
  localparam logic [3:0] UPD_CNT = 4'(`SRC_UPD_CYC);

  // Refuse settings the logic cannot serve
  if (CODE_FLASH_KB < 1 || ADDR_W < 8 || ADDR_W > 31 || `SRC_UPD_CYC > 15) begin : g_bad
    $error("src_top: unsupported parameter values");
  end

  logic                 optSwap, optDual, optBank;
  logic                 dualMode;
  logic                 hitA, hitB;
  // Bus state
  logic                 awready_q, awready_d, bvalid_q, bvalid_d, arready_q, arready_d;
  logic                 rvalid_q, rvalid_d;
  logic [1:0]           bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]          rdata_q, rdata_d;
  logic                 wrFire, arFire, wrMapped;
  logic [31:0]          wmask, wval;
  // Control registers
  src_pkg::src_sel_t    sel_q, sel_d;
  logic                 cacheEn_q, cacheEn_d;
  logic [31:0]          raLo_q, raLo_d, raHi_q, raHi_d, rbLo_q, rbLo_d, rbHi_q, rbHi_d;
  logic [31:0]          freq_q, freq_d;
  logic [1:0]           irqSt_q, irqSt_d, irqMsk_q, irqMsk_d, irqSet;
  logic [3:0]           updCnt_q, updCnt_d;
  logic                 swapWr, toggleReq;
  // Bank and boot state
  src_pkg::src_bank_st_t bankSt_q, bankSt_d;
  logic                 pendBank_q, pendBank_d, activeBank_q, activeBank_d;
  logic                 booted_q, booted_d, bankWrite_q, bankWrite_d;
  logic                 bankData_q, bankData_d;
  logic [2:0]           bootCnt_q, bootCnt_d;
  // Output flops
  logic                 region_q, region_d, cacheAct_q, cacheAct_d, cached_q, cached_d;
  logic                 ready_q, ready_d, dfWait_q, dfWait_d, irq_q, irq_d;

  // Option memory levels come from another domain
  src_sync #(.W(3)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .din    ({optSwapFlag, optDualMode, optBankCode}),
    .dout   ({optSwap, optDual, optBank})
  );

  assign dualMode = BIG && optDual;

  // Two uncached windows, each with its own enable
  src_range #(.AW(ADDR_W)) u_range_a (
    .addr (accessAddr),
    .lo   (raLo_q[ADDR_W-1:0]),
    .hi   (raHi_q[ADDR_W-1:0]),
    .en   (raLo_q[`SRC_RANGE_EN]),
    .hit  (hitA)
  );
  src_range #(.AW(ADDR_W)) u_range_b (
    .addr (accessAddr),
    .lo   (rbLo_q[ADDR_W-1:0]),
    .hi   (rbHi_q[ADDR_W-1:0]),
    .en   (rbLo_q[`SRC_RANGE_EN]),
    .hit  (hitB)
  );

  // Address and data are taken together; the master holds both until then
  assign wrFire = awready_q && s_axi_awvalid && s_axi_wvalid;
  assign arFire = arready_q && s_axi_arvalid;
  assign wmask  = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                   {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign wval   = s_axi_wdata & wmask;

  // Bus handshake and read data
  always_comb begin
    awready_d = booted_q && s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
    arready_d = booted_q && s_axi_arvalid && !arready_q && !rvalid_q;
    bvalid_d  = wrFire || (bvalid_q && !s_axi_bready);
    bresp_d   = bresp_q;
    rvalid_d  = arFire || (rvalid_q && !s_axi_rready);
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    wrMapped  = (s_axi_awaddr <= `SRC_IRQ_MSK) && (s_axi_awaddr[1:0] == 2'h0);
    if (wrFire) begin
      bresp_d = wrMapped ? 2'h0 : 2'h2;
    end
    if (arFire) begin
      rresp_d = 2'h0;
      case (s_axi_araddr)
        `SRC_CTRL:    rdata_d = {23'h0, 1'b0, 3'h0, cacheEn_q, 2'h0, sel_q};
        `SRC_STAT:    rdata_d = {26'h0, (updCnt_q != 4'h0), pendBank_q, activeBank_q,
                                 dualMode, region_q, cacheAct_q};
        `SRC_RA_LO:   rdata_d = raLo_q;
        `SRC_RA_HI:   rdata_d = raHi_q;
        `SRC_RB_LO:   rdata_d = rbLo_q;
        `SRC_RB_HI:   rdata_d = rbHi_q;
        `SRC_FREQ:    rdata_d = freq_q;
        `SRC_IRQ_ST:  rdata_d = {30'h0, irqSt_q};
        `SRC_IRQ_MSK: rdata_d = {30'h0, irqMsk_q};
        default: begin
          rdata_d = 32'h0;
          rresp_d = 2'h2;
        end
      endcase
    end
  end

  // Bus flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awready_q <= 1'b0;
      arready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= 2'h0;
    end else begin
      awready_q <= awready_d;
      arready_q <= arready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // Control register writes; hardware set beats software clear
  always_comb begin
    sel_d     = sel_q;
    cacheEn_d = cacheEn_q;
    raLo_d    = raLo_q;
    raHi_d    = raHi_q;
    rbLo_d    = rbLo_q;
    rbHi_d    = rbHi_q;
    freq_d    = freq_q;
    irqMsk_d  = irqMsk_q;
    swapWr    = 1'b0;
    toggleReq = 1'b0;
    updCnt_d  = (updCnt_q != 4'h0) ? updCnt_q - 4'h1 : 4'h0;
    irqSet    = 2'h0;
    irqSet[`SRC_IRQ_RDY] = ready_q;
    irqSet[`SRC_IRQ_UPD] = (updCnt_q == 4'h1);
    irqSt_d   = irqSt_q;
    if (wrFire) begin
      case (s_axi_awaddr)
        `SRC_CTRL: begin
          // Select is ignored in dual mode; software keeps off it there
          if (s_axi_wstrb[0] && !dualMode) begin
            sel_d  = src_pkg::src_sel_t'(s_axi_wdata[`SRC_CTRL_SEL +: 2]);
            swapWr = (sel_d == src_pkg::SWAP_REGION);
          end
          if (s_axi_wstrb[0]) begin
            cacheEn_d = s_axi_wdata[`SRC_CTRL_CACHE];
          end
          // Toggle only honoured in dual mode
          toggleReq = s_axi_wstrb[1] && s_axi_wdata[`SRC_CTRL_TOG] && dualMode;
        end
        `SRC_RA_LO:   raLo_d = (raLo_q & ~wmask) | wval;
        `SRC_RA_HI:   raHi_d = (raHi_q & ~wmask) | wval;
        `SRC_RB_LO:   rbLo_d = (rbLo_q & ~wmask) | wval;
        `SRC_RB_HI:   rbHi_d = (rbHi_q & ~wmask) | wval;
        `SRC_FREQ:    freq_d = (freq_q & ~wmask) | wval;
        `SRC_IRQ_ST:  irqSt_d = irqSt_q & ~s_axi_wdata[1:0];
        `SRC_IRQ_MSK: irqMsk_d = s_axi_wdata[1:0];
        default: ;
      endcase
      // Lookups must not hit stale ranges while one is rewritten
      if (cacheEn_q && (s_axi_awaddr >= `SRC_RA_LO) && (s_axi_awaddr <= `SRC_RB_HI)) begin
        updCnt_d = UPD_CNT;
      end
    end
    irqSt_d = irqSt_d | irqSet;
  end

  // Control register flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_q     <= src_pkg::FOLLOW_OPTION_SETTING;
      cacheEn_q <= 1'b0;
      raLo_q    <= 32'h0;
      raHi_q    <= 32'h0;
      rbLo_q    <= 32'h0;
      rbHi_q    <= 32'h0;
      freq_q    <= `SRC_FREQ_RST;
      irqSt_q   <= 2'h0;
      irqMsk_q  <= 2'h0;
      updCnt_q  <= 4'h0;
    end else begin
      sel_q     <= sel_d;
      cacheEn_q <= cacheEn_d;
      raLo_q    <= raLo_d;
      raHi_q    <= raHi_d;
      rbLo_q    <= rbLo_d;
      rbHi_q    <= rbHi_d;
      freq_q    <= freq_d;
      irqSt_q   <= irqSt_d;
      irqMsk_q  <= irqMsk_d;
      updCnt_q  <= updCnt_d;
    end
  end

  // Boot capture and bank toggle sequence
  always_comb begin
    bootCnt_d    = booted_q ? bootCnt_q : bootCnt_q + 3'h1;
    booted_d     = booted_q || (bootCnt_q == `SRC_BOOT_CYC);
    activeBank_d = activeBank_q;
    pendBank_d   = pendBank_q;
    bankSt_d     = bankSt_q;
    bankWrite_d  = 1'b0;
    bankData_d   = bankData_q;
    ready_d      = swapWr;
    // Stored bank code sampled once the synchroniser has settled
    if (!booted_q && booted_d) begin
      activeBank_d = BIG ? optBank : `SRC_BANK0_CODE;
      pendBank_d   = activeBank_d;
    end
    case (bankSt_q)
      src_pkg::BANK_IDLE: begin
        if (toggleReq) begin
          bankSt_d = src_pkg::BANK_WRITE;
        end
      end
      src_pkg::BANK_WRITE: begin
        // Only the stored value moves; the active bank waits for reset
        pendBank_d  = ~pendBank_q;
        bankWrite_d = 1'b1;
        bankData_d  = ~pendBank_q;
        bankSt_d    = src_pkg::BANK_NOTIFY;
      end
      src_pkg::BANK_NOTIFY: begin
        ready_d  = 1'b1;
        bankSt_d = src_pkg::BANK_IDLE;
      end
      default: bankSt_d = src_pkg::BANK_IDLE;
    endcase
  end

  // Bank flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bootCnt_q    <= 3'h0;
      booted_q     <= 1'b0;
      activeBank_q <= `SRC_BANK0_CODE;
      pendBank_q   <= `SRC_BANK0_CODE;
      bankSt_q     <= src_pkg::BANK_IDLE;
      bankWrite_q  <= 1'b0;
      bankData_q   <= 1'b0;
    end else begin
      bootCnt_q    <= bootCnt_d;
      booted_q     <= booted_d;
      activeBank_q <= activeBank_d;
      pendBank_q   <= pendBank_d;
      bankSt_q     <= bankSt_d;
      bankWrite_q  <= bankWrite_d;
      bankData_q   <= bankData_d;
    end
  end

  // Region, cache and interrupt outputs
  always_comb begin
    case (sel_q)
      src_pkg::FOLLOW_OPTION_SETTING: region_d = ~optSwap; // A clear flag means swapped
      src_pkg::FORCE_REGION_ZERO:     region_d = 1'b0;
      src_pkg::FORCE_REGION_ONE:      region_d = 1'b1;
      src_pkg::SWAP_REGION:           region_d = optSwap;
      default:                        region_d = 1'b0;
    endcase
    cacheAct_d = cacheEn_q && (updCnt_q == 4'h0);
    cached_d   = accessValid && cacheAct_d && !hitA && !hitB;
    dfWait_d   = BIG && (freq_q > `SRC_DF_FAST);
    irq_d      = |(irqSt_d & irqMsk_d);
  end

  // Output flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      region_q   <= 1'b0;
      cacheAct_q <= 1'b0;
      cached_q   <= 1'b0;
      ready_q    <= 1'b0;
      dfWait_q   <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      region_q   <= region_d;
      cacheAct_q <= cacheAct_d;
      cached_q   <= cached_d;
      ready_q    <= ready_d;
      dfWait_q   <= dfWait_d;
      irq_q      <= irq_d;
    end
  end

  assign s_axi_awready   = awready_q;
  assign s_axi_wready    = awready_q;
  assign s_axi_bvalid    = bvalid_q;
  assign s_axi_bresp     = bresp_q;
  assign s_axi_arready   = arready_q;
  assign s_axi_rvalid    = rvalid_q;
  assign s_axi_rdata     = rdata_q;
  assign s_axi_rresp     = rresp_q;
  assign activeRegion    = region_q;
  assign activeBank      = activeBank_q;
  assign cacheActive     = cacheAct_q;
  assign accessCached    = cached_q;
  assign bankWrite       = bankWrite_q;
  assign bankWriteData   = bankData_q;
  assign flashReadyEvent = ready_q;
  assign flashFreq       = freq_q;
  assign dataFlashWait   = dfWait_q;
  assign irq             = irq_q;

  // Checks
  a_region_force: assert property (@(posedge clk) disable iff (!resetn)
    wrFire && s_axi_awaddr == `SRC_CTRL && s_axi_wstrb[0] && !dualMode
    && s_axi_wdata[1:0] == 2'h2 |=> ##1 region_q)
    else $error("forced region one not applied");
  a_select_reset: assert property (@(posedge clk) disable iff (!resetn)
    !booted_q |-> sel_q == src_pkg::FOLLOW_OPTION_SETTING)
    else $error("select not follow after reset");
  a_cache_status: assert property (@(posedge clk) disable iff (!resetn)
    ##1 cacheAct_q == $past(cacheEn_q && updCnt_q == 4'h0))
    else $error("cache status wrong");
  a_range_bypass: assert property (@(posedge clk) disable iff (!resetn)
    accessValid && (hitA || hitB) |=> !cached_q)
    else $error("uncached range cached");
  a_update_off: assert property (@(posedge clk) disable iff (!resetn)
    wrFire && cacheEn_q && s_axi_awaddr == `SRC_RA_HI |=> ##1 !cacheAct_q [*4])
    else $error("cache not paused on range update");
  a_bank_hold: assert property (@(posedge clk) disable iff (!resetn)
    booted_q && $past(booted_q) |-> $stable(activeBank_q))
    else $error("active bank changed without reset");
  a_bank_ready: assert property (@(posedge clk) disable iff (!resetn)
    bankWrite_q |=> ready_q)
    else $error("no ready after bank write");
  a_ready_single: assert property (@(posedge clk) disable iff (!resetn)
    bankSt_q == src_pkg::BANK_NOTIFY |=> ready_q && bankSt_q == src_pkg::BANK_IDLE
    ##1 !ready_q && !bankWrite_q)
    else $error("bank notify not single");
  a_small_nodual: assert property (@(posedge clk) disable iff (!resetn)
    !BIG |-> !dualMode && bankSt_q == src_pkg::BANK_IDLE && !dfWait_q)
    else $error("dual feature on small flash");
  a_swap_ready: assert property (@(posedge clk) disable iff (!resetn)
    swapWr |=> ready_q)
    else $error("no ready after swap");
  c_toggle: cover property (@(posedge clk) disable iff (!resetn) bankWrite_q ##1 ready_q);
  c_update: cover property (@(posedge clk) disable iff (!resetn) updCnt_q == 4'h1);
  c_swap:   cover property (@(posedge clk) disable iff (!resetn) swapWr);
  c_irq:    cover property (@(posedge clk) disable iff (!resetn) $rose(irq_q));
endmodule // src_top
`default_nettype wire

// ===== verilog/src_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 200 MHz clock, AXI4-Lite byte addresses
// Notes:   Definitions only
`ifndef SRC_DEFS_SVH
`define SRC_DEFS_SVH
// Register byte offsets
`define SRC_CTRL       8'h00
`define SRC_STAT       8'h04
`define SRC_RA_LO      8'h08
`define SRC_RA_HI      8'h0C
`define SRC_RB_LO      8'h10
`define SRC_RB_HI      8'h14
`define SRC_FREQ       8'h18
`define SRC_IRQ_ST     8'h1C
`define SRC_IRQ_MSK    8'h20
// Field positions
`define SRC_CTRL_SEL   0
`define SRC_CTRL_CACHE 4
`define SRC_CTRL_TOG   8
`define SRC_RANGE_EN   31
`define SRC_IRQ_RDY    0
`define SRC_IRQ_UPD    1
// Reset values and codes
`define SRC_FREQ_RST   32'h0000_0020
`define SRC_DF_FAST    32'h0000_0020
`define SRC_BANK0_CODE 1'b1
// Timing
`define SRC_CLK_MHZ    200
`define SRC_UPD_NS     20
`define SRC_UPD_CYC    ((`SRC_UPD_NS * `SRC_CLK_MHZ + 999) / 1000)
`define SRC_BOOT_CYC   3'h4
`endif

// ===== verilog/src_pkg.sv
// Purpose: Types shared by the startup region and cache control block
// Assumes: Nothing
// Notes:   Select encoding follows enum order
`default_nettype none
package src_pkg;
  typedef enum logic [1:0] {
    FOLLOW_OPTION_SETTING,
    FORCE_REGION_ZERO,
    FORCE_REGION_ONE,
    SWAP_REGION
  } src_sel_t;
  typedef enum logic [1:0] {BANK_IDLE, BANK_WRITE, BANK_NOTIFY} src_bank_st_t;
endpackage
`default_nettype wire

// ===== verilog/src_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk
// Notes:   Output changes only once stages two and three agree
`default_nettype none
module src_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] ff1_q, ff2_q, ff3_q, out_q, out_d;

  // Accept a new level only when stable across two stages
  always_comb begin
    out_d = (ff2_q == ff3_q) ? ff3_q : out_q;
  end

  // Stage one feeds stage two only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ff1_q <= '0;
      ff2_q <= '0;
      ff3_q <= '0;
      out_q <= '0;
    end else begin
      ff1_q <= din;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      out_q <= out_d;
    end
  end
  assign dout = out_q;
endmodule // src_sync
`default_nettype wire

// ===== verilog/src_range.sv
// Purpose: Inclusive address range hit detector
// Assumes: lo not above hi for a useful range
// Notes:   Purely combinational
`default_nettype none
module src_range #(
  parameter int AW = 24
) (
  input  wire logic [AW-1:0] addr,
  input  wire logic [AW-1:0] lo,
  input  wire logic [AW-1:0] hi,
  input  wire logic          en,
  output var  logic          hit
);
  // Disabled range never matches
  always_comb begin
    hit = en && (addr >= lo) && (addr <= hi);
  end
endmodule // src_range
`default_nettype wire

// ===== tb/startup_region_cache_control_bench.sv
// Purpose: Self-checking bench for src_top over AXI4-Lite
// Assumes: One 200 MHz clock, option pins held stable across each reset release
// Notes:   Random values come from a fixed xorshift seed, so every run repeats
`include "src_defs.svh"
`default_nettype none
module startup_region_cache_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'h0;
  logic        resetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        optSwap = 1'h1;
  logic        optDual = 1'h0;
  logic        optBank = 1'h1;
  logic [23:0] accessAddr = 24'h0;
  logic        accessValid = 1'h0;
  logic        activeRegion, activeBank, cacheActive, accessCached, bankWrite, bankWriteData;
  logic        flashReadyEvent, dataFlashWait, irq, wrData;
  logic [31:0] flashFreq;
  logic [31:0] seed = 32'h8213;
  int          failCount = 0;
  int          checkCount = 0;
  int          rdyCount = 0;
  int          wrCount = 0;
  int          pauseCount = 0;

  src_top i_dut (
    .clk(clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .optSwapFlag(optSwap), .optDualMode(optDual), .optBankCode(optBank),
    .accessAddr(accessAddr), .accessValid(accessValid), .activeRegion(activeRegion),
    .activeBank(activeBank), .cacheActive(cacheActive), .accessCached(accessCached),
    .bankWrite(bankWrite), .bankWriteData(bankWriteData), .flashReadyEvent(flashReadyEvent),
    .flashFreq(flashFreq), .dataFlashWait(dataFlashWait), .irq(irq));

  // Clock of 5 ns period
  always #2.5 clk = ~clk;

  // Event counters; counting ready and bank write pulses also shows each lasts one cycle; the pause count only shows a pause happened
  always @(posedge clk) begin
    if (flashReadyEvent === 1'h1) rdyCount++;
    if (bankWrite === 1'h1) begin
      wrCount++;
      wrData = bankWriteData;
    end
    if (cacheActive === 1'h0) pauseCount++;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected region for a select code and the stored swap flag
  function automatic logic expRegion(input logic [1:0] s, input logic sw);
    case (s)
      2'h0: return ~sw;
      2'h1: return 1'h0;
      2'h2: return 1'h1;
      default: return sw;
    endcase
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tmo(input string m);
    failCount++;
    $display("ERROR %0t timeout %s", $time, m);
    complete_run();
  endtask

  task automatic chk1(input logic g, input logic e, input string m);
    checkCount++;
    if (g !== e) begin
      failCount++;
      $display("ERROR %0t %s got %b", $time, m, g);
    end
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
    checkCount++;
    if (g !== e) begin
      failCount++;
      $display("ERROR %0t %s got %h want %h", $time, m, g, e);
    end
  endtask

  // Write; address and data are each held until their own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) break;
    end
    if (n == 200) tmo("write");
    s_axi_bready <= 1'h0;
    chk32({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) break;
    end
    if (n == 200) tmo("read");
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    chk32({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
  endtask

  // Option pins change only while reset is held, so the sync sees stable levels
  task automatic boot(input logic sw, input logic du, input logic bk);
    resetn <= 1'h0;
    optSwap <= sw;
    optDual <= du;
    optBank <= bk;
    repeat (10) @(posedge clk);
    resetn <= 1'h1;
    repeat (20) @(posedge clk);
  endtask

  task automatic probe(input logic [23:0] a, input logic e);
    @(posedge clk);
    accessAddr <= a;
    accessValid <= 1'h1;
    @(posedge clk);
    accessValid <= 1'h0;
    #1;
    chk1(accessCached, e, "cached");
  endtask

  initial begin
    logic [31:0] d, lo, hi, v;
    int          k, c, p;
    boot(1'h1, 1'h0, 1'h1);
    chk1(activeBank, 1'h1, "bank at boot");
    chk32(flashFreq, `SRC_FREQ_RST, "freq reset");
    rd(`SRC_CTRL, 2'h0, d);
    chk32(d & 32'h3, 32'h0, "select reset");
    chk1(activeRegion, 1'h0, "region reset");
    $display("test reset done");
    // Every select code under both swap flag values
    for (k = 0; k < 8; k++) begin
      if (k == 4) boot(1'h0, 1'h0, 1'h1);
      if (k == 4) chk1(activeRegion, 1'h1, "region boot");
      c = rdyCount;
      wr(`SRC_CTRL, {30'h0, k[1:0]}, 2'h0);
      repeat (3) @(posedge clk);
      chk1(activeRegion, expRegion(k[1:0], optSwap), "region");
      chk32(rdyCount - c, (k[1:0] == 2'h3) ? 1 : 0, "swap event");
    end
    $display("test region done");
    // Ready flag left by the last swap drives irq once unmasked
    chk1(irq, 1'h0, "irq masked");
    wr(`SRC_IRQ_MSK, 32'h1, 2'h0);
    repeat (2) @(posedge clk);
    chk1(irq, 1'h1, "irq set");
    wr(`SRC_IRQ_ST, 32'h1, 2'h0);
    repeat (2) @(posedge clk);
    chk1(irq, 1'h0, "irq clear");
    $display("test irq done");
    wr(`SRC_CTRL, 32'h10, 2'h0);
    rd(`SRC_STAT, 2'h0, d);
    chk1(d[0], 1'h1, "cache on");
    // Range A in the lower half, B in the upper half, so they never overlap
    for (k = 0; k < 2; k++) begin
      v = rnd();
      lo = {8'h00, k[0], 1'h0, v[21:8], 8'h00};
      hi = lo + 32'h100;
      p = pauseCount;
      wr(k ? `SRC_RB_LO : `SRC_RA_LO, lo | 32'h8000_0000, 2'h0);
      wr(k ? `SRC_RB_HI : `SRC_RA_HI, hi, 2'h0);
      repeat (8) @(posedge clk);
      chk1(pauseCount != p, 1'h1, "pause");
      chk1(cacheActive, 1'h1, "resume");
      probe(lo[23:0], 1'h0);
      probe(hi[23:0], 1'h0);
      probe(hi[23:0] + 24'h1, 1'h1);
    end
    rd(`SRC_IRQ_ST, 2'h0, d);
    chk1(d[1], 1'h1, "update flag");
    wr(`SRC_CTRL, 32'h0, 2'h0); // Cache off before option memory is rewritten
    rd(`SRC_STAT, 2'h0, d);
    chk1(d[0], 1'h0, "cache off");
    probe(hi[23:0] + 24'h1, 1'h0);
    $display("test cache done");
    // Threshold corners first, then random frequencies
    for (k = 0; k < 6; k++) begin
      v = (k < 2) ? 32'h20 + k : rnd();
      wr(`SRC_FREQ, v, 2'h0);
      rd(`SRC_FREQ, 2'h0, d);
      chk32(d, v, "freq read");
      chk32(flashFreq, v, "freq out");
      chk1(dataFlashWait, v > 32'h20, "data wait");
    end
    wr(8'h40, 32'h1, 2'h2);
    rd(8'h44, 2'h2, d);
    chk32(d, 32'h0, "unmapped");
    p = wrCount;
    wr(`SRC_CTRL, 32'h100, 2'h0);
    repeat (6) @(posedge clk);
    chk32(wrCount - p, 32'h0, "linear toggle");
    $display("test freq done");
    // Dual mode: toggle writes option memory, active bank waits for reset
    boot(1'h1, 1'h1, 1'h0);
    chk1(activeBank, 1'h0, "bank one");
    rd(`SRC_STAT, 2'h0, d);
    chk1(d[3], 1'h0, "bank code");
    c = rdyCount;
    p = wrCount;
    wr(`SRC_CTRL, 32'h102, 2'h0);
    repeat (6) @(posedge clk);
    chk32(wrCount - p, 32'h1, "bank write");
    chk1(wrData, 1'h1, "bank data");
    chk32(rdyCount - c, 32'h1, "bank ready");
    chk1(activeBank, 1'h0, "bank held");
    chk1(activeRegion, 1'h0, "dual select");
    boot(1'h1, 1'h1, wrData);
    chk1(activeBank, 1'h1, "bank after reset");
    $display("test bank done");
    complete_run();
  end
endmodule // startup_region_cache_control_bench
`default_nettype wire
